//--- hdl/lsc_cfg.svh
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH
// ****************************************
// register offsets (command address field)
// ****************************************
`define LSC_OFS_CTRL 5'h00
`define LSC_OFS_TIMING 5'h01
`define LSC_OFS_ICFG 5'h02
`define LSC_OFS_TLO_L 5'h03
`define LSC_OFS_TLO_H 5'h04
`define LSC_OFS_THI_L 5'h05
`define LSC_OFS_THI_H 5'h06
`define LSC_OFS_D0L 5'h14
`define LSC_OFS_D0H 5'h15
`define LSC_OFS_D1L 5'h16
`define LSC_OFS_D1H 5'h17
// ****************************************
// command byte and register fields
// ****************************************
`define LSC_CMD_BIT 7
`define LSC_TYPE_WORD 2'h1
`define LSC_TYPE_SPECIAL 2'h3
`define LSC_SF_INT_CLR 5'h00
`define LSC_CTRL_PWR 0
`define LSC_CTRL_ADC_EN 1
`define LSC_CTRL_RUN 2'h3
`define LSC_STY_OFF 2'h0
`define LSC_STY_LEVEL 2'h1
`define LSC_STY_ALERT 2'h2
`define LSC_ARA_ADDR 7'h0C
`define LSC_SLV_ADDR 7'h29
// ****************************************
// reset values
// ****************************************
`define LSC_CTRL_RST 2'h0
`define LSC_INTEGRATION_PERIOD_VALUE_RST 8'hFF
`define LSC_ICFG_RST 8'h00
`define LSC_TLO_RST 16'h0000
`define LSC_THI_RST 16'hFFFF
// ****************************************
// timing
// ****************************************
`define LSC_CLK_HZ 50000000
`define LSC_INTEGRATION_PERIOD_VALUE_REF_MS 200
`define LSC_INTEGRATION_PERIOD_VALUE_REF_VAL 8'hB6
`define LSC_STEP_CYC ((`LSC_CLK_HZ / 1000 * `LSC_INTEGRATION_PERIOD_VALUE_REF_MS) / (256 - `LSC_INTEGRATION_PERIOD_VALUE_REF_VAL))
`endif

//--- hdl/lsc_pkg.sv
// ****************************************
// types
// ****************************************
package lsc_pkg;
  typedef enum {
    SL_IDLE, SL_ADDR, SL_CMD, SL_WDAT, SL_RDAT, SL_ARA, SL_ARD
  } lsc_slv_st_t;
endpackage : lsc_pkg

//--- hdl/lsc_light_ctrl.sv
`timescale 1ns/100ps
`include "lsc_cfg.svh"
// How it works
// - reset leaves converter powered down, idle
// - control write 01h powers the device
// - one enable bit starts both channels
// - command 0x80 selects control register
// - command 0x81 selects timing; 0xb6 is 200 ms
// - control 0x03 powers and enables at once
// - word read 0xb4 returns 0x14 then 0x15
// - word read 0xb6 returns 0x16 then 0x17
// - style field picks interrupt mode; 00h off
// - two 16-bit thresholds bound the window
// - only channel 0 is compared
// - persistence 1 fires on first outside
// - N outside in a row; inside restarts
// - interrupt low until cleared
// - special command clear releases level style
// - alert response releases alert style
// - persistence 0 fires every conversion
// - channel 0 broadband, channel 1 infrared
// - low-byte read latches high byte shadow
module lsc_light_ctrl
  import lsc_pkg::*;
#(
  parameter logic [6:0] SLV_ADDR = `LSC_SLV_ADDR,
  parameter int unsigned STEP_CYC = `LSC_STEP_CYC
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // two-wire link
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  output logic int_oe_o,
  // converter front end
  input wire logic [15:0] broadband_channel_i,
  input wire logic [15:0] infrared_channel_i,
  output logic integrate_o
);

  // ****************************************
  // link pin synchronisers and bus events
  // ****************************************
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // two stages, then a third for edges
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign bus_start = scl_s_q[2] & scl_s_q[1] & sda_s_q[2] & ~sda_s_q[1];
  assign bus_stop = scl_s_q[2] & scl_s_q[1] & ~sda_s_q[2] & sda_s_q[1];

  // ****************************************
  // link side registers
  // ****************************************
  lsc_slv_st_t st_q;
  logic [3:0] bit_q;
  logic ack_q;
  logic hnack_q;
  logic drv_q;
  logic [7:0] shr_q;
  logic [7:0] txs_q;
  logic [4:0] ptr_q;
  logic word_q;
  logic [1:0] ctrl_q;
  logic [7:0] integration_period_value_q;
  logic [7:0] icfg_q;
  logic [15:0] thr_lo_q;
  logic [15:0] thr_hi_q;
  logic [15:0] data0_q;
  logic [15:0] data1_q;
  logic [7:0] shadow0_q;
  logic [7:0] shadow1_q;
  logic cfg_tgl_q;
  logic [2:0] res_s_q;
  logic [3:0] pers_q;
  logic pend_q;
  logic pend_d;
  // system side result holding
  logic [15:0] res0_q;
  logic [15:0] res1_q;
  logic res_tgl_q;

  // ****************************************
  // decoded link events
  // ****************************************
  logic ack_start;
  logic ack_end;
  logic cmd_stb;
  logic wr_stb;
  logic ld_rd;
  logic ara_done;
  logic sf_clr;
  logic own_hit;
  logic ara_hit;
  logic [1:0] cmd_type;
  logic [1:0] style;
  logic [3:0] persist;
  logic res_stb;
  logic win_out;
  logic fire;
  logic [7:0] rd_mux;
  logic [7:0] tx_byte;

  assign ack_start = scl_fall & ~ack_q & (bit_q == 4'h8) & (st_q != SL_IDLE);
  assign ack_end = scl_fall & ack_q;
  assign cmd_type = shr_q[6:5];
  assign cmd_stb = ack_start & (st_q == SL_CMD) & shr_q[`LSC_CMD_BIT];
  assign wr_stb = ack_start & (st_q == SL_WDAT);
  assign ld_rd = ack_end & (st_q == SL_RDAT) & ~hnack_q;
  assign ara_done = ack_end & (st_q == SL_ARD);
  assign sf_clr = cmd_stb & (cmd_type == `LSC_TYPE_SPECIAL)
                & (shr_q[4:0] == `LSC_SF_INT_CLR);
  assign style = icfg_q[5:4];
  assign persist = icfg_q[3:0];
  assign own_hit = (shr_q[7:1] == SLV_ADDR);
  // alert address only answered while an alert is pending
  assign ara_hit = (shr_q[7:1] == `LSC_ARA_ADDR) & shr_q[0] & pend_q
                 & (style == `LSC_STY_ALERT);

  // read data by pointer; data high bytes come from the shadow, threshold high bytes direct
  always_comb begin
    case (ptr_q)
      `LSC_OFS_CTRL: rd_mux = {6'h00, ctrl_q};
      `LSC_OFS_TIMING: rd_mux = integration_period_value_q;
      `LSC_OFS_ICFG: rd_mux = icfg_q;
      `LSC_OFS_TLO_L: rd_mux = thr_lo_q[7:0];
      `LSC_OFS_TLO_H: rd_mux = thr_lo_q[15:8];
      `LSC_OFS_THI_L: rd_mux = thr_hi_q[7:0];
      `LSC_OFS_THI_H: rd_mux = thr_hi_q[15:8];
      `LSC_OFS_D0L: rd_mux = data0_q[7:0];
      `LSC_OFS_D0H: rd_mux = shadow0_q;
      `LSC_OFS_D1L: rd_mux = data1_q[7:0];
      `LSC_OFS_D1H: rd_mux = shadow1_q;
      default: rd_mux = 8'h00;
    endcase
  end

  assign tx_byte = (st_q == SL_ARA) ? {SLV_ADDR, 1'b0} : rd_mux;

  // ****************************************
  // target state machine
  // ****************************************
  // shifts on scl rise, drives sda on scl fall
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= SL_IDLE;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      hnack_q <= 1'b0;
      drv_q <= 1'b0;
      shr_q <= 8'h00;
      txs_q <= 8'h00;
    end else if (bus_start) begin
      st_q <= SL_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      hnack_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (bus_stop) begin
      st_q <= SL_IDLE;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      if (scl_rise && !ack_q && bit_q < 4'h8) begin
        shr_q <= {shr_q[6:0], sda_s_q[1]};
        bit_q <= bit_q + 4'h1;
      end
      if (scl_rise && ack_q) begin
        hnack_q <= sda_s_q[1];
      end
      if (ack_start) begin
        ack_q <= 1'b1;
        bit_q <= 4'h0;
        case (st_q)
          SL_ADDR: begin
            if (own_hit) begin
              st_q <= shr_q[0] ? SL_RDAT : SL_CMD;
              drv_q <= 1'b1;
            end else if (ara_hit) begin
              st_q <= SL_ARA;
              drv_q <= 1'b1;
            end else begin
              st_q <= SL_IDLE;
              drv_q <= 1'b0;
            end
          end
          SL_CMD, SL_WDAT: begin
            st_q <= SL_WDAT;
            drv_q <= 1'b1;
          end
          default: begin
            drv_q <= 1'b0;
          end
        endcase
      end else if (ack_end) begin
        ack_q <= 1'b0;
        case (st_q)
          SL_RDAT: begin
            if (hnack_q) begin
              st_q <= SL_IDLE;
              drv_q <= 1'b0;
            end else begin
              txs_q <= tx_byte;
              drv_q <= ~tx_byte[7];
            end
          end
          SL_ARA: begin
            st_q <= SL_ARD;
            txs_q <= tx_byte;
            drv_q <= ~tx_byte[7];
          end
          SL_ARD: begin
            st_q <= SL_IDLE;
            drv_q <= 1'b0;
          end
          default: begin
            drv_q <= 1'b0;
          end
        endcase
      end else if (scl_fall && !ack_q && bit_q != 4'h0 && bit_q < 4'h8
                   && (st_q == SL_RDAT || st_q == SL_ARD)) begin
        txs_q <= {txs_q[6:0], 1'b0};
        drv_q <= ~txs_q[6];
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = drv_q;

  // ****************************************
  // pointer, register writes, shadows
  // ****************************************
  // command byte loads pointer; word accesses step it
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= 5'h00;
      word_q <= 1'b0;
    end else if (cmd_stb && cmd_type != `LSC_TYPE_SPECIAL) begin
      ptr_q <= shr_q[4:0];
      word_q <= (cmd_type == `LSC_TYPE_WORD);
    end else if ((wr_stb || ld_rd) && word_q) begin
      ptr_q <= ptr_q + 5'h01;
    end
  end

  // register file writes
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `LSC_CTRL_RST;
      integration_period_value_q <= `LSC_INTEGRATION_PERIOD_VALUE_RST;
      icfg_q <= `LSC_ICFG_RST;
      thr_lo_q <= `LSC_TLO_RST;
      thr_hi_q <= `LSC_THI_RST;
      cfg_tgl_q <= 1'b0;
    end else if (wr_stb) begin
      case (ptr_q)
        `LSC_OFS_CTRL: begin
          ctrl_q <= shr_q[1:0];
          cfg_tgl_q <= ~cfg_tgl_q;
        end
        `LSC_OFS_TIMING: begin
          integration_period_value_q <= shr_q;
          cfg_tgl_q <= ~cfg_tgl_q;
        end
        `LSC_OFS_ICFG: icfg_q <= shr_q;
        `LSC_OFS_TLO_L: thr_lo_q[7:0] <= shr_q;
        `LSC_OFS_TLO_H: thr_lo_q[15:8] <= shr_q;
        `LSC_OFS_THI_L: thr_hi_q[7:0] <= shr_q;
        `LSC_OFS_THI_H: thr_hi_q[15:8] <= shr_q;
        default: ;
      endcase
    end
  end

  // low byte read latches the matching high byte
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shadow0_q <= 8'h00;
      shadow1_q <= 8'h00;
    end else if (ld_rd && ptr_q == `LSC_OFS_D0L) begin
      shadow0_q <= data0_q[15:8];
    end else if (ld_rd && ptr_q == `LSC_OFS_D1L) begin
      shadow1_q <= data1_q[15:8];
    end
  end

  // ****************************************
  // result arrival from system domain
  // ****************************************
  // toggle crossing; result words are held steady meanwhile
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_s_q <= 3'h0;
    end else begin
      res_s_q <= {res_s_q[1:0], res_tgl_q};
    end
  end

  assign res_stb = res_s_q[2] ^ res_s_q[1];

  // data registers, double buffered behind res0_q/res1_q
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data0_q <= 16'h0000;
      data1_q <= 16'h0000;
    end else if (res_stb) begin
      data0_q <= res0_q;
      data1_q <= res1_q;
    end
  end

  // ****************************************
  // window, persistence and interrupt line
  // ****************************************
  assign win_out = (res0_q < thr_lo_q) || (res0_q > thr_hi_q);
  // count compared on five bits so a count saturated at fifteen still fires
  assign fire = res_stb && style != `LSC_STY_OFF
              && (persist == 4'h0
              || (win_out && {1'b0, pers_q} + 5'h01 >= {1'b0, persist}));

  // consecutive outside count, saturating at the setting
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pers_q <= 4'h0;
    end else if (res_stb) begin
      if (persist == 4'h0 || !win_out) begin
        pers_q <= 4'h0;
      end else if (pers_q < persist) begin
        pers_q <= pers_q + 4'h1;
      end
    end
  end

  // pending interrupt; a new event beats a same-cycle clear
  always_comb begin
    pend_d = pend_q;
    if (sf_clr && style == `LSC_STY_LEVEL) begin
      pend_d = 1'b0;
    end
    if (ara_done) begin
      pend_d = 1'b0;
    end
    if (fire) begin
      pend_d = 1'b1;
    end
    if (style == `LSC_STY_OFF || style == 2'h3) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign int_oe_o = pend_q;
  assign int_n_o = ~pend_q;

  // ****************************************
  // system domain: settings and integration
  // ****************************************
  logic [2:0] cfg_s_q;
  logic run_pwr_q;
  logic run_en_q;
  logic [7:0] run_integration_period_value_q;
  logic [31:0] step_q;
  logic [8:0] steps_q;
  logic run;
  logic [8:0] steps_last;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_s_q <= 3'h0;
    end else begin
      cfg_s_q <= {cfg_s_q[1:0], cfg_tgl_q};
    end
  end

  // settings taken on each crossed write event
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_pwr_q <= 1'b0;
      run_en_q <= 1'b0;
      run_integration_period_value_q <= `LSC_INTEGRATION_PERIOD_VALUE_RST;
    end else if (cfg_s_q[2] ^ cfg_s_q[1]) begin
      run_pwr_q <= ctrl_q[`LSC_CTRL_PWR];
      run_en_q <= ctrl_q[`LSC_CTRL_ADC_EN];
      run_integration_period_value_q <= integration_period_value_q;
    end
  end

  assign run = run_pwr_q & run_en_q;
  assign integrate_o = run;
  assign steps_last = 9'h0FF - {1'b0, run_integration_period_value_q};

  // period is (256 - setting) steps of STEP_CYC cycles
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_q <= 32'h0;
      steps_q <= 9'h000;
    end else if (!run) begin
      step_q <= 32'h0;
      steps_q <= 9'h000;
    end else if (step_q >= 32'(STEP_CYC - 1)) begin
      step_q <= 32'h0;
      steps_q <= (steps_q >= steps_last) ? 9'h000 : steps_q + 9'h001;
    end else begin
      step_q <= step_q + 32'h1;
    end
  end

  // both channels captured together at period end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res0_q <= 16'h0000;
      res1_q <= 16'h0000;
      res_tgl_q <= 1'b0;
    end else if (run && step_q >= 32'(STEP_CYC - 1) && steps_q >= steps_last) begin
      res0_q <= broadband_channel_i;
      res1_q <= infrared_channel_i;
      res_tgl_q <= ~res_tgl_q;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  pwr_down_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !run |=> $stable(res_tgl_q)) else $error("conversion while powered down");
  both_en_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cfg_s_q[2] ^ cfg_s_q[1]) && ctrl_q == `LSC_CTRL_RUN |=> integrate_o && step_q == 32'h0)
    else $error("enable did not start both channels");
  pwr_up_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    wr_stb && ptr_q == `LSC_OFS_CTRL |=> ctrl_q == $past(shr_q[1:0]))
    else $error("control write lost");
  word_step_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    ld_rd && word_q && ptr_q == `LSC_OFS_D0L |=> ptr_q == `LSC_OFS_D0H)
    else $error("word read did not advance");
  shadow_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    ld_rd && ptr_q == `LSC_OFS_D0L |=> shadow0_q == $past(data0_q[15:8]) ##1 $stable(shadow0_q))
    else $error("shadow not latched");
  first_out_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    res_stb && persist == 4'h1 && win_out && style == `LSC_STY_LEVEL |=> pend_q)
    else $error("persistence 1 missed");
  persist_rst_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    res_stb && !win_out
    |=> pers_q == 4'h0 && (!pend_q || $past(pend_q) || $past(persist) == 4'h0))
    else $error("inside result kept count");
  eoc_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    res_stb && persist == 4'h0 && style == `LSC_STY_ALERT |=> pend_q [*2])
    else $error("end of conversion missed");
  int_hold_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    pend_q && !sf_clr && !ara_done && (style == `LSC_STY_LEVEL || style == `LSC_STY_ALERT)
    |=> int_oe_o && !int_n_o) else $error("interrupt released early");
  lvl_clr_a: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    sf_clr && style == `LSC_STY_LEVEL && !fire |=> !int_oe_o)
    else $error("level clear ignored");
  lvl_int_c: cover property (@(posedge clk_link_i) disable iff (!rst_n_i)
    fire && style == `LSC_STY_LEVEL ##[1:1000] sf_clr);
  ara_c: cover property (@(posedge clk_link_i) disable iff (!rst_n_i) ara_done);
  word_rd_c: cover property (@(posedge clk_link_i) disable iff (!rst_n_i)
    ld_rd && ptr_q == `LSC_OFS_D0H);
  persist_c: cover property (@(posedge clk_link_i) disable iff (!rst_n_i)
    fire && persist > 4'h1);

endmodule : lsc_light_ctrl

//--- testbench/lsc_host_model.sv
`timescale 1ns/100ps
`include "lsc_cfg.svh"
// ****************************************
// two-wire bus controller model
// ****************************************
module lsc_host_model (
  // timing reference
  input wire logic clk_sys_i,
  // bus pins
  input wire logic sda_oe_i,
  input wire logic sda_dev_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv_q;
  logic [15:0] rd_w;
  event done_e;
  // wired-and with pull-up, released line reads high
  assign sda_o = drv_q & ~(sda_oe_i & ~sda_dev_i);
  // bus idles released
  initial begin
    scl_o = 1'b1;
    drv_q = 1'b1;
  end
  // wait k system clocks, then step off the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : tick
  // start or repeated start, clock left low
  task automatic start();
    tick(20);
    drv_q = 1'b1;
    tick(20);
    scl_o = 1'b1;
    tick(20);
    drv_q = 1'b0;
    tick(20);
    scl_o = 1'b0;
  endtask : start
  // stop, bus released
  task automatic stop();
    tick(20);
    drv_q = 1'b0;
    tick(20);
    scl_o = 1'b1;
    tick(20);
    drv_q = 1'b1;
    tick(20);
  endtask : stop
  // one bit: data set well after the fall, sampled before the next fall
  task automatic bit_io(input logic b, output logic r);
    tick(5);
    drv_q = b;
    tick(20);
    scl_o = 1'b1;
    tick(20);
    r = sda_o;
    scl_o = 1'b0;
  endtask : bit_io
  // eight bits msb first plus the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] r,
      output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ai, ao);
  endtask : byte_io
  // command write, optional data bytes, optional read after repeated start
  task automatic xact(input logic [7:0] cmd, input logic [31:0] wd, input int nw,
      input int nr);
    logic [7:0] r;
    logic a;
    start();
    // cleared only after the checker has taken the previous word
    rd_w = 16'h0000;
    byte_io({`LSC_SLV_ADDR, 1'b0}, 1'b1, r, a);
    byte_io(cmd, 1'b1, r, a);
    for (int i = 0; i < nw; i++) byte_io(wd[8*i+:8], 1'b1, r, a);
    if (nr > 0) begin
      start();
      byte_io({`LSC_SLV_ADDR, 1'b1}, 1'b1, r, a);
      for (int i = 0; i < nr; i++) begin
        byte_io(8'hFF, (i == nr - 1), r, a);
        rd_w[8*i+:8] = r;
      end
    end
    stop();
    if (nr > 0) -> done_e;
  endtask : xact
  // alert response read, last byte not acknowledged
  task automatic ara();
    logic [7:0] r;
    logic a;
    start();
    byte_io({`LSC_ARA_ADDR, 1'b1}, 1'b1, r, a);
    byte_io(8'hFF, 1'b1, r, a);
    stop();
    rd_w = {8'h00, r};
    -> done_e;
  endtask : ara
endmodule : lsc_host_model

//--- testbench/light_sensor_ctrl_interrupt_bench.sv
`timescale 1ns/100ps
`include "lsc_cfg.svh"
// ****************************************
// self-checking bench
// ****************************************
module light_sensor_ctrl_interrupt_bench;
  localparam int STEP = 20;
  localparam int PER = (256 - 182) * STEP; // period at the 200 ms timing value
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_n_i;
  logic scl, sda, sda_o, sda_oe_o, int_n_o, int_oe_o, integrate_o;
  logic [15:0] bb_d, ir_d, ch0, ch1, old0;
  logic [15:0] exp_q[$];
  string nm_q[$];
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 16;
  int cyc = 0;
  int n;
  // clocks, link clock unrelated in phase
  always #10 clk_sys_i = ~clk_sys_i;
  initial begin
    #7;
    forever #15 clk_link_i = ~clk_link_i;
  end
  // design and bus controller
  lsc_light_ctrl #(.STEP_CYC(STEP)) lsc_light_ctrl_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o), .int_oe_o(int_oe_o),
    .broadband_channel_i(bb_d), .infrared_channel_i(ir_d), .integrate_o(integrate_o)
  );
  lsc_host_model lsc_host_model_i (
    .clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe_o), .sda_dev_i(sda_o), .scl_o(scl), .sda_o(sda)
  );
  // compare tasks
  task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word
  task automatic check_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  // read results compared against the oldest note
  initial forever begin
    @(lsc_host_model_i.done_e);
    check_word(nm_q.pop_front(), exp_q.pop_front(), lsc_host_model_i.rd_w);
  end
  // bus and stimulus helpers
  task automatic rd(input logic [7:0] cmd, input int nr, input logic [15:0] e,
      input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    lsc_host_model_i.xact(cmd, 32'h0, 0, nr);
  endtask : rd
  task automatic wr(input logic [7:0] cmd, input logic [31:0] d, input int nw);
    lsc_host_model_i.xact(cmd, d, nw, 0);
  endtask : wr
  task automatic ara_rd();
    exp_q.push_back({8'h00, `LSC_SLV_ADDR, 1'b0});
    nm_q.push_back("alert address");
    lsc_host_model_i.ara();
  endtask : ara_rd
  task automatic drive(input logic [15:0] c0, input logic [15:0] c1);
    @(posedge clk_sys_i);
    #1;
    bb_d = c0;
    ir_d = c1;
  endtask : drive
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : idle
  task automatic wait_low(input int k);
    for (n = 0; n < k && int_n_o !== 1'b0; n++) @(posedge clk_sys_i);
    #1;
  endtask : wait_low
  // closing report
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // hang guard, about half again the expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      summarize();
    end
  end
  // main sequence
  initial begin
    bb_d = 16'h0000;
    ir_d = 16'h0000;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    idle(100);
    check_bit("integrate at reset", 1'b0, integrate_o);
    check_bit("int at reset", 1'b1, int_n_o);
    rd(8'hB4, 2, 16'h0000, "data0 at reset");
    wr(8'h80, 32'h01, 1);
    idle(20);
    check_bit("integrate powered only", 1'b0, integrate_o);
    wr(8'h81, 32'hB6, 1);
    rd(8'h81, 1, 16'h00B6, "timing");
    wr(8'h80, 32'h03, 1);
    idle(20);
    check_bit("integrate enabled", 1'b1, integrate_o);
    $display("test power up done");
    ch0 = 16'($random(seed));
    ch1 = ch0 >> 2;
    drive(ch0, ch1);
    idle(2 * PER);
    rd(8'hB4, 2, ch0, "data0 word");
    rd(8'hB6, 2, ch1, "data1 word");
    rd(8'h94, 1, {8'h00, ch0[7:0]}, "data0 low");
    old0 = ch0;
    drive(~ch0, ch1);
    idle(2 * PER);
    rd(8'h95, 1, {8'h00, old0[15:8]}, "data0 shadow");
    rd(8'h9F, 1, 16'h0000, "unmapped");
    $display("test readout done");
    wr(8'hA3, 32'h8000_1000, 4);
    wr(8'h82, 32'h00, 1);
    drive(16'h9000, 16'h0000);
    idle(2 * PER);
    check_bit("int disabled", 1'b1, int_n_o);
    drive(16'h4000, 16'hFFFF);
    wr(8'h82, 32'h11, 1);
    idle(2 * PER);
    check_bit("int channel 1 ignored", 1'b1, int_n_o);
    drive(16'h9000, 16'h0000);
    wait_low(PER + 200);
    check_bit("int first outside", 1'b0, int_n_o);
    check_bit("int drive on", 1'b1, int_oe_o);
    drive(16'h4000, 16'h0000);
    idle(2 * PER);
    check_bit("int held", 1'b0, int_n_o);
    wr(8'hE0, 32'h0, 0);
    idle(10);
    check_bit("int level clear", 1'b1, int_n_o);
    check_bit("int drive off", 1'b0, int_oe_o);
    $display("test level interrupt done");
    wr(8'h82, 32'h13, 1);
    drive(16'h0800, 16'h0000);
    idle(PER * 3 / 2);
    check_bit("int before count", 1'b1, int_n_o);
    drive(16'h4000, 16'h0000);
    idle(PER * 3 / 2);
    drive(16'h0800, 16'h0000);
    idle(2 * PER - 20);
    check_bit("int count restarted", 1'b1, int_n_o);
    wait_low(2 * PER + 200);
    check_bit("int after count", 1'b0, int_n_o);
    drive(16'h4000, 16'h0000);
    idle(PER + 100);
    wr(8'hE0, 32'h0, 0);
    $display("test persistence done");
    wr(8'h82, 32'h20, 1);
    repeat (2) begin
      wait_low(PER + 200);
      check_bit("int end of conversion", 1'b0, int_n_o);
      ara_rd();
    end
    idle(10);
    check_bit("int alert clear", 1'b1, int_n_o);
    $display("test alert done");
    summarize();
  end
endmodule : light_sensor_ctrl_interrupt_bench
